// File: hdl/control_source_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_src_defines.svh"

// What this block does
// - Address plug fixes station address, blocks changes
// - Test plug forces manual local mode
// - Inputs one, two drive motor plus brake
// - Inputs three, four lose start, direction actions
// - Submodule data loaded only at restart
// - Program command writes parameters to submodule
// - Clear command erases, submodule then ignored
// - Five submodule status flags reported
// - Latched submodule flags cleared by trip reset
// - Three modes: automatic, manual bus, local
// - Automatic mode obeys only the PLC
// - Manual bus obeys only bus PC
// - Local mode: inputs or local PC, PC first
// - Higher mode always seizes control from lower
// - Return downward only with motor off
// - Five status bits encode active source
// - Supervision runs only in manual modes
// - No record for five seconds stops motor
// - Empty record 93 refreshes, commands zero
// - Return to automatic needs motor off; the command also needs brake off
module control_source_arbiter
   import ctrl_src_pkg::*;
#(
   parameter int unsigned WDOG_CYCLES = `WDOG_CYCLES,
   parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 addrPlugPresent,
   input  wire logic [6:0]           addrPlugValue,
   input  wire logic                 testPlugPresent,
   input  wire logic                 localPcPresent,
   input  wire logic [3:0]           digitalIn,
   input  wire logic                 subPresent,
   input  wire logic                 subDefective,
   input  wire logic                 subWriteDone,
   input  wire logic                 subWriteError,
   output logic                      subWriteStrobe,
   output logic                      subEraseStrobe,
   output logic                      subLoadStrobe,
   output ctrl_src_pkg::stationAddr_t stationAddr,
   output logic                      motor_forward_action,
   output logic                      motor_reverse_action,
   output logic                      brakeOut,
   output logic [4:0]                sourceStatus,
   output logic                      link_timeout_flag
);
   import ctrl_src_pkg::*;

   // ==================================================================
   // Pin synchronisers
   logic [14:0] pinMeta_q;
   logic [14:0] pinSync_q;
   logic [14:0] pinRaw;
   assign pinRaw = {addrPlugPresent, addrPlugValue, testPlugPresent, localPcPresent,
                    digitalIn, subPresent};

   // No reset: live levels must stand when reset lifts, or the
   // restart load and the absent flag would see an empty slot
   always_ff @(posedge clk) begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
   end

   logic       plugIn;
   logic [6:0] plugAddr;
   logic       testPlug;
   logic       localPc;
   logic [3:0] dIn;
   logic       subIn;
   assign plugIn   = pinSync_q[14];
   assign plugAddr = pinSync_q[13:7];
   assign testPlug = pinSync_q[6];
   assign localPc  = pinSync_q[5];
   assign dIn      = pinSync_q[4:1];
   assign subIn    = pinSync_q[0];

   logic [3:0] subFlagMeta_q;
   logic [3:0] subFlagSync_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         subFlagMeta_q <= 4'h0;
         subFlagSync_q <= 4'h0;
      end else begin
         subFlagMeta_q <= {subDefective, subWriteDone, subWriteError, 1'b0};
         subFlagSync_q <= subFlagMeta_q;
      end
   end

   // ==================================================================
   // APB access decode
   logic wrAcc;
   logic rdAcc;
   logic mapped;
   assign wrAcc  = psel && penable && pwrite;
   assign rdAcc  = psel && penable && !pwrite;
   assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_CMD) ||
                   (paddr == `REG_STATUS) || (paddr == `REG_SUBMOD) ||
                   (paddr == `REG_ADDR) || (paddr == `REG_WRREC) ||
                   (paddr == `REG_INPUTS);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   function automatic logic isWr(input logic [7:0] a, input logic [7:0] off);
      isWr = wrAcc && (a == off);
   endfunction

   logic       cmdValid;
   logic [3:0] cmdCode;
   logic       recWrite;
   logic [7:0] recNum;
   assign cmdValid = isWr(paddr, `REG_CMD);
   assign cmdCode  = pwdata[3:0];
   assign recWrite = isWr(paddr, `REG_WRREC);
   assign recNum   = pwdata[15:8];

   // ==================================================================
   // Source and mode state
   opMode_t      mode_q, mode_d;
   logic [1:0]   busCmd_q, busCmd_d;
   logic         busBrake_q, busBrake_d;
   logic [7:0]   inAction_q, inAction_d;
   stationAddr_t swAddr_q, swAddr_d;
   logic         localInput_q, localInput_d;
   logic         timeout_q, timeout_d;
   logic [31:0]  wdog_q, wdog_d;
   logic         fwd, rev, brk;
   logic         motorOn;
   logic         manualInput;
   logic         abortMotor;

   // Input action field per input: bit0 forward, bit1 reverse, except input four's bit1 selects manual
   assign manualInput = inAction_q[7] && dIn[3];
   assign motorOn     = motor_forward_action || motor_reverse_action;

   always_comb begin
      mode_d       = mode_q;
      busCmd_d     = busCmd_q;
      busBrake_d   = busBrake_q;
      inAction_d   = inAction_q;
      swAddr_d     = swAddr_q;
      localInput_d = localInput_q;
      timeout_d    = timeout_q;
      wdog_d       = wdog_q;
      abortMotor   = 1'b0;

      if (isWr(paddr, `REG_CTRL)) begin
         inAction_d   = pwdata[7:0];
         localInput_d = pwdata[8];
      end
      if (isWr(paddr, `REG_ADDR) && !plugIn && pwdata[6:0] <= `ADDR_MAX) begin
         swAddr_d = pwdata[6:0];
      end

      // Upward takeover is unconditional; downward needs motor idle
      if (testPlug || manualInput || localPc) begin
         mode_d = MODE_MANLOCAL;
      end else if (cmdValid) begin
         unique case (cmdCode)
            `CMD_MANLOCAL: mode_d = MODE_MANLOCAL;
            `CMD_MANBUS: begin
               if (mode_q != MODE_MANLOCAL) begin
                  mode_d = MODE_MANBUS;
               end
            end
            `CMD_AUTO: begin
               if (!motorOn && !brakeOut) begin
                  mode_d = MODE_AUTO;
               end
            end
            default: ;
         endcase
      end else if (mode_q == MODE_MANLOCAL && !motorOn && inAction_q[7] && !dIn[3]
                   && !localInput_q) begin
         mode_d = MODE_AUTO;
      end

      // Record writes: source accepted only if it owns the current mode
      if (recWrite) begin
         if ((mode_q == MODE_AUTO && pwdata[17:16] == 2'd0) ||
             (mode_q == MODE_MANBUS && pwdata[17:16] == 2'd1) ||
             (mode_q == MODE_MANLOCAL && pwdata[17:16] == 2'd2)) begin
            wdog_d    = 32'h0;
            timeout_d = 1'b0;
            if (recNum == `REC_EMPTY) begin
               busCmd_d   = 2'b00;
               busBrake_d = 1'b0;
            end else begin
               busCmd_d   = pwdata[1:0];
               busBrake_d = pwdata[2];
            end
         end
      end

      if (mode_q == MODE_AUTO) begin
         wdog_d    = 32'h0;
         timeout_d = 1'b0;
      end else if (!recWrite) begin
         if (wdog_q >= WDOG_CYCLES - 1) begin
            timeout_d  = 1'b1;
            abortMotor = 1'b1;
         end else begin
            wdog_d = wdog_q + 32'h1;
         end
      end
      if (abortMotor || mode_d != mode_q) begin
         busCmd_d   = 2'b00;
         busBrake_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q       <= MODE_AUTO;
         busCmd_q     <= 2'b00;
         busBrake_q   <= 1'b0;
         inAction_q   <= `INACT_RST;
         swAddr_q     <= `ADDR_RST;
         localInput_q <= 1'b0;
         timeout_q    <= 1'b0;
         wdog_q       <= 32'h0;
      end else begin
         mode_q       <= mode_d;
         busCmd_q     <= busCmd_d;
         busBrake_q   <= busBrake_d;
         inAction_q   <= inAction_d;
         swAddr_q     <= swAddr_d;
         localInput_q <= localInput_d;
         timeout_q    <= timeout_d;
         wdog_q       <= wdog_d;
      end
   end

   // ==================================================================
   // Drive selection
   logic inputCtl;
   assign inputCtl = (mode_q == MODE_MANLOCAL) && !localPc && (localInput_q || testPlug);

   always_comb begin
      fwd = busCmd_q[0];
      brk = busBrake_q;
      rev = busCmd_q[1];
      if (inputCtl) begin
         if (testPlug) begin
            fwd = dIn[0];
            rev = dIn[1];
            brk = dIn[0] || dIn[1];
            // Inputs three and four keep only non-drive actions
         end else begin
            fwd = (dIn[0] && inAction_q[0]) || (dIn[1] && inAction_q[2]) ||
                  (dIn[2] && inAction_q[4]);
            rev = (dIn[0] && inAction_q[1]) || (dIn[1] && inAction_q[3]) ||
                  (dIn[2] && inAction_q[5]);
            brk = 1'b0;
         end
         // Drive actions on inputs three and four are masked in test mode
         if (!testPlug) begin
            fwd = fwd || (dIn[3] && inAction_q[6] && !inAction_q[7]);
         end
      end
      if (timeout_q || (fwd && rev)) begin
         fwd = 1'b0;
         rev = 1'b0;
         brk = 1'b0;
      end
   end

   logic fwd_q, rev_q, brk_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fwd_q <= 1'b0;
         rev_q <= 1'b0;
         brk_q <= 1'b0;
      end else begin
         fwd_q <= fwd;
         rev_q <= rev;
         brk_q <= brk;
      end
   end
   assign motor_forward_action = fwd_q;
   assign motor_reverse_action = rev_q;
   assign brakeOut             = brk_q;

   // Plug address wins over the software value while attached
   assign stationAddr = plugIn ? plugAddr : swAddr_q;

   logic [4:0] srcStat;
   always_comb begin
      unique case (mode_q)
         MODE_AUTO:   srcStat = 5'b10000;
         MODE_MANBUS: srcStat = {4'b0100, timeout_q};
         default:     srcStat = {2'b00, 1'b1, inputCtl && !timeout_q, timeout_q};
      endcase
   end
   assign sourceStatus      = srcStat;
   assign link_timeout_flag = timeout_q;

   // ==================================================================
   // Memory submodule
   subState_t  sub_q, sub_d;
   logic [7:0] subCnt_q, subCnt_d;
   logic       erased_q, erased_d;
   logic       fAbsent_q, fAbsent_d;
   logic       fDefect_q, fDefect_d;
   logic       fOk_q, fOk_d;
   logic       fErr_q, fErr_d;
   logic       loadDone_q, loadDone_d;
   logic       wrStb, erStb, ldStb;
   logic       tripReset;
   assign tripReset = cmdValid && cmdCode == `CMD_TRIPRESET;

   always_comb begin
      sub_d      = sub_q;
      subCnt_d   = subCnt_q;
      erased_d   = erased_q;
      loadDone_d = loadDone_q;
      wrStb      = 1'b0;
      erStb      = 1'b0;
      ldStb      = 1'b0;
      fAbsent_d  = fAbsent_q && !tripReset;
      fDefect_d  = fDefect_q && !tripReset;
      fOk_d      = fOk_q && !tripReset;
      fErr_d     = fErr_q && !tripReset;
      if (!loadDone_q) begin
         loadDone_d = 1'b1;
         ldStb      = subIn && !erased_q;
      end
      if (cmdValid && cmdCode == `CMD_RESTART && mode_q != MODE_AUTO) begin
         loadDone_d = 1'b0;
      end
      if (!subIn) begin
         fAbsent_d = 1'b1;
      end
      if (subFlagSync_q[3]) begin
         fDefect_d = 1'b1;
      end
      unique case (sub_q)
         SM_IDLE: begin
            if (cmdValid && subIn && cmdCode == `CMD_PROGRAM) begin
               sub_d    = SM_PROG;
               wrStb    = 1'b1;
               subCnt_d = 8'h00;
               erased_d = 1'b0;
            end else if (cmdValid && subIn && cmdCode == `CMD_CLEAR) begin
               sub_d    = SM_ERASE;
               erStb    = 1'b1;
            end
         end
         SM_PROG: begin
            // Set wins over a simultaneous trip reset
            if (subFlagSync_q[2]) begin
               fOk_d = 1'b1;
               sub_d = SM_IDLE;
            end else if (subFlagSync_q[1] || !subIn) begin
               fErr_d = 1'b1;
               sub_d  = SM_IDLE;
            end
         end
         default: begin
            erased_d = 1'b1;
            sub_d    = SM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sub_q      <= SM_IDLE;
         subCnt_q   <= 8'h00;
         erased_q   <= 1'b0;
         fAbsent_q  <= 1'b0;
         fDefect_q  <= 1'b0;
         fOk_q      <= 1'b0;
         fErr_q     <= 1'b0;
         loadDone_q <= 1'b0;
      end else begin
         sub_q      <= sub_d;
         subCnt_q   <= subCnt_d;
         erased_q   <= erased_d;
         fAbsent_q  <= fAbsent_d;
         fDefect_q  <= fDefect_d;
         fOk_q      <= fOk_d;
         fErr_q     <= fErr_d;
         loadDone_q <= loadDone_d;
      end
   end

   logic wrStb_q, erStb_q, ldStb_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrStb_q <= 1'b0;
         erStb_q <= 1'b0;
         ldStb_q <= 1'b0;
      end else begin
         wrStb_q <= wrStb;
         erStb_q <= erStb;
         ldStb_q <= ldStb;
      end
   end
   assign subWriteStrobe = wrStb_q;
   assign subEraseStrobe = erStb_q;
   assign subLoadStrobe  = ldStb_q;

   logic [4:0] subStat;
   assign subStat = {fErr_q, fOk_q, sub_q == SM_PROG, fDefect_q, fAbsent_q};

   // ==================================================================
   // Read data
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0;
      if (rdAcc) begin
         unique case (paddr)
            `REG_CTRL:   rd_d = {23'h0, localInput_q, inAction_q};
            `REG_STATUS: rd_d = {24'h0, 1'b0, mode_q, sourceStatus};
            `REG_SUBMOD: rd_d = {26'h0, erased_q, subStat};
            `REG_ADDR:   rd_d = {24'h0, plugIn, stationAddr};
            `REG_INPUTS: rd_d = {25'h0, brakeOut, motor_reverse_action,
                                 motor_forward_action, dIn};
            default:     rd_d = 32'h0;
         endcase
      end
   end
   // Zero-wait reads return combinational decode of registered state
   assign prdata = rd_d;
endmodule

`default_nettype wire

// File: hdl/ctrl_src_defines.svh
`ifndef CTRL_SRC_DEFINES_SVH
`define CTRL_SRC_DEFINES_SVH

// =====================================================================
// Register map (APB byte addresses)
`define REG_CTRL       8'h00
`define REG_CMD        8'h04
`define REG_STATUS     8'h08
`define REG_SUBMOD     8'h0c
`define REG_ADDR       8'h10
`define REG_WRREC      8'h14
`define REG_INPUTS     8'h18

// =====================================================================
// Command codes written to REG_CMD
`define CMD_AUTO       4'h1
`define CMD_MANBUS     4'h2
`define CMD_MANLOCAL   4'h3
`define CMD_PROGRAM    4'h4
`define CMD_CLEAR      4'h5
`define CMD_TRIPRESET  4'h6
`define CMD_RESTART    4'h7

// =====================================================================
// Record numbers, timing and limits
`define REC_EMPTY      8'd93
`define ADDR_MAX       7'd127
`define WDOG_SECONDS   5
`define CLK_HZ         20000000
`define WDOG_CYCLES    (`WDOG_SECONDS * `CLK_HZ)
`define PROG_CYCLES    16

// =====================================================================
// Reset values
`define ADDR_RST       7'h7e
`define INACT_RST      8'h00

`endif

// File: hdl/ctrl_src_pkg.sv
package ctrl_src_pkg;
   typedef enum logic [1:0] {MODE_AUTO, MODE_MANBUS, MODE_MANLOCAL} opMode_t;
   typedef enum logic [1:0] {SM_IDLE, SM_PROG, SM_ERASE} subState_t;
   typedef logic [6:0] stationAddr_t;
endpackage

// File: testbench/bus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_src_defines.svh"
// ==========================================
// Host on the far side: PLC or PC issuing transfers
module bus_host_model (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid after release
      pwdata <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      xfer(1'b0, a, 32'h0, q, e);
   endtask
   // Empty record keeps supervision alive with no commands
   task automatic keepAlive(input logic [1:0] src);
      wr(`REG_WRREC, {14'h0, src, `REC_EMPTY, 8'h00});
   endtask
endmodule
`default_nettype wire

// File: testbench/ctrl_src_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_src_defines.svh"
// ==========================================
// Port checker for the arbiter
module ctrl_src_props #(
   parameter int unsigned WDOG_CYCLES = 50
) (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                addrPlugPresent,
   input wire logic [6:0]          addrPlugValue,
   input wire logic                testPlugPresent,
   input wire logic [3:0]          digitalIn,
   input wire logic                subPresent,
   input wire logic                subWriteStrobe,
   input wire logic                subEraseStrobe,
   input wire logic                subLoadStrobe,
   input wire ctrl_src_pkg::stationAddr_t stationAddr,
   input wire logic                motor_forward_action,
   input wire logic                motor_reverse_action,
   input wire logic                brakeOut,
   input wire logic [4:0]          sourceStatus,
   input wire logic                link_timeout_flag
);
   import ctrl_src_pkg::*;
   int   quietCnt_q, quietCnt_d, rstCnt_q, rstCnt_d;
   logic cmdWr;
   assign cmdWr = psel && penable && pwrite && paddr == `REG_CMD;
   // Saturate so long idle stretches cannot wrap
   always_comb begin
      quietCnt_d = (quietCnt_q < 1000) ? quietCnt_q + 1 : quietCnt_q;
      rstCnt_d = (rstCnt_q < 1000) ? rstCnt_q + 1 : rstCnt_q;
      if (psel && penable && pwrite) quietCnt_d = 0;
      if (cmdWr && pwdata[3:0] == `CMD_RESTART) rstCnt_d = 0;
   end
   always_ff @(posedge clk) begin
      quietCnt_q <= sys_rst ? 0 : quietCnt_d;
      rstCnt_q <= sys_rst ? 0 : rstCnt_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   statusCode_a: assert property (!$past(sys_rst) |-> sourceStatus inside
      {5'b10000, 5'b01000, 5'b00100, 5'b00110, 5'b01001, 5'b00101}) else $error("bad source code");
   plugAddr_a: assert property ((addrPlugPresent && $stable(addrPlugValue))[*4]
      |-> stationAddr == addrPlugValue) else $error("plug address not used");
   timeoutStop_a: assert property ($rose(link_timeout_flag)
      |-> ##[0:1] !(motor_forward_action || motor_reverse_action)) else $error("motor runs on abort");
   abortBit_a: assert property ($rose(link_timeout_flag) |-> ##[0:1] sourceStatus[0])
      else $error("abort bit missing");
   autoNoSup_a: assert property (sourceStatus == 5'b10000 |=> !$rose(link_timeout_flag))
      else $error("supervision in automatic");
   wdogLate_a: assert property (quietCnt_q == WDOG_CYCLES + 4 && sourceStatus[3]
      |-> link_timeout_flag) else $error("supervision did not expire");
   progStrobe_a: assert property (cmdWr && pwdata[3:0] == `CMD_PROGRAM && subPresent
      |-> ##[1:3] subWriteStrobe) else $error("no program strobe");
   clearStrobe_a: assert property (cmdWr && pwdata[3:0] == `CMD_CLEAR && subPresent
      |-> ##[1:3] subEraseStrobe) else $error("no erase strobe");
   loadRestart_a: assert property (subLoadStrobe |-> rstCnt_q < 16)
      else $error("load outside restart");
   plugFwd_a: assert property ((testPlugPresent && digitalIn == 4'b0001)[*6]
      |-> motor_forward_action && brakeOut && !motor_reverse_action) else $error("plug input one");
   cover property ($rose(link_timeout_flag));
   cover property (subWriteStrobe);
   cover property (testPlugPresent && brakeOut);
endmodule
`default_nettype wire

// File: testbench/test_control_source_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_src_defines.svh"
// ==========================================
// Arbiter bench
module test_control_source_arbiter;
   import ctrl_src_pkg::*;
   localparam int unsigned WDOG = 50;
   typedef struct packed {
      logic [3:0]  cmd;
      logic [31:0] rec;
      logic [1:0]  motor;
      logic [4:0]  status;
   } row_t;
   logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic         addrPlugPresent, testPlugPresent, localPcPresent, subPresent;
   logic         subDefective, subWriteDone, subWriteError, subWriteStrobe;
   logic         subEraseStrobe, subLoadStrobe, brakeOut, link_timeout_flag;
   logic         motor_forward_action, motor_reverse_action;
   logic [3:0]   digitalIn;
   logic [4:0]   sourceStatus;
   logic [6:0]   addrPlugValue;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, q;
   stationAddr_t stationAddr;
   int           mismatches, compares, cycles, loads, writes, erases, n;
   row_t         rows [8] = '{
      '{4'h0, 32'h0000_0101, 2'b01, 5'b10000},
      '{4'h0, 32'h0001_0102, 2'b01, 5'b10000},
      '{`CMD_MANBUS, 32'h0001_0101, 2'b01, 5'b01000},
      '{4'h0, 32'h0000_0100, 2'b01, 5'b01000},
      '{`CMD_AUTO, 32'h0001_0101, 2'b01, 5'b01000},
      '{4'h0, 32'h0001_5d02, 2'b00, 5'b01000},
      '{`CMD_AUTO, 32'h0000_0101, 2'b01, 5'b10000},
      '{4'h0, 32'h0000_0100, 2'b00, 5'b10000}};
   control_source_arbiter #(.WDOG_CYCLES(WDOG)) uut (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .addrPlugPresent(addrPlugPresent), .addrPlugValue(addrPlugValue),
      .testPlugPresent(testPlugPresent), .localPcPresent(localPcPresent),
      .digitalIn(digitalIn), .subPresent(subPresent), .subDefective(subDefective),
      .subWriteDone(subWriteDone), .subWriteError(subWriteError),
      .subWriteStrobe(subWriteStrobe), .subEraseStrobe(subEraseStrobe),
      .subLoadStrobe(subLoadStrobe), .stationAddr(stationAddr),
      .motor_forward_action(motor_forward_action), .motor_reverse_action(motor_reverse_action),
      .brakeOut(brakeOut), .sourceStatus(sourceStatus), .link_timeout_flag(link_timeout_flag));
   bus_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic final_report;
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (subLoadStrobe === 1'b1) loads++;
      if (subWriteStrobe === 1'b1) writes++;
      if (subEraseStrobe === 1'b1) erases++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      sys_rst = 1'b1;
      {addrPlugPresent, testPlugPresent, localPcPresent, subDefective} = 4'h0;
      {subWriteDone, subWriteError, digitalIn, addrPlugValue} = 13'h0;
      subPresent = 1'b1;
      wt(10);
      sys_rst <= 1'b0;
      wt(4);
      chk(sourceStatus, 5'b10000);
      chk(loads, 1);
      foreach (rows[i]) begin
         if (rows[i].cmd != 4'h0) host.wr(`REG_CMD, {28'h0, rows[i].cmd});
         host.wr(`REG_WRREC, rows[i].rec);
         wt(2);
         chk({motor_reverse_action, motor_forward_action}, rows[i].motor);
         chk(sourceStatus, rows[i].status);
      end
      wt(WDOG + 10);
      chk(link_timeout_flag, 1'b0);
      host.wr(`REG_CMD, `CMD_MANBUS);
      repeat (3) begin
         wt(WDOG - 20);
         host.keepAlive(2'd1);
      end
      chk(link_timeout_flag, 1'b0);
      host.wr(`REG_WRREC, 32'h0001_0101);
      n = 0;
      while (link_timeout_flag !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(n >= WDOG - 1 && n <= WDOG + 4, 1);
      wt(2);
      chk({motor_reverse_action, motor_forward_action}, 2'b00);
      chk(sourceStatus, 5'b01001);
      host.wr(`REG_CMD, `CMD_AUTO);
      wt(2);
      chk(sourceStatus, 5'b10000);
      host.wr(`REG_CTRL, 32'h10);
      testPlugPresent <= 1'b1;
      digitalIn <= 4'b0001;
      wt(6);
      chk(sourceStatus[2], 1'b1);
      chk({brakeOut, motor_reverse_action, motor_forward_action}, 3'b101);
      digitalIn <= 4'b0010;
      wt(6);
      chk({brakeOut, motor_reverse_action, motor_forward_action}, 3'b110);
      digitalIn <= 4'b0100;
      wt(6);
      chk({brakeOut, motor_reverse_action, motor_forward_action}, 3'b000);
      digitalIn <= 4'b0000;
      testPlugPresent <= 1'b0;
      addrPlugValue <= 7'h2a;
      addrPlugPresent <= 1'b1;
      wt(4);
      chk(stationAddr, 7'h2a);
      host.wr(`REG_ADDR, 32'h11);
      addrPlugPresent <= 1'b0;
      wt(4);
      chk(stationAddr, `ADDR_RST);
      host.wr(`REG_CMD, `CMD_PROGRAM);
      host.rd(`REG_SUBMOD, q, err);
      chk(q[2], 1'b1);
      chk(writes, 1);
      subWriteDone <= 1'b1;
      wt(3);
      subWriteDone <= 1'b0;
      wt(3);
      host.rd(`REG_SUBMOD, q, err);
      chk(q[3:2], 2'b10);
      host.wr(`REG_CMD, `CMD_TRIPRESET);
      host.rd(`REG_SUBMOD, q, err);
      chk(q[3], 1'b0);
      host.wr(`REG_CMD, `CMD_CLEAR);
      wt(3);
      chk(erases, 1);
      host.rd(`REG_SUBMOD, q, err);
      chk(q[5], 1'b1);
      host.rd(8'h40, q, err);
      chk(err, 1'b1);
      localPcPresent <= 1'b1;
      host.wr(`REG_WRREC, 32'h0002_0101);
      wt(3);
      chk({motor_reverse_action, motor_forward_action}, 2'b01);
      chk(sourceStatus, 5'b00100);
      final_report();
   end
endmodule
bind control_source_arbiter ctrl_src_props #(.WDOG_CYCLES(WDOG_CYCLES)) props (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .addrPlugPresent(addrPlugPresent),
   .addrPlugValue(addrPlugValue), .testPlugPresent(testPlugPresent),
   .digitalIn(digitalIn), .subPresent(subPresent), .subWriteStrobe(subWriteStrobe),
   .subEraseStrobe(subEraseStrobe), .subLoadStrobe(subLoadStrobe),
   .stationAddr(stationAddr), .motor_forward_action(motor_forward_action),
   .motor_reverse_action(motor_reverse_action), .brakeOut(brakeOut),
   .sourceStatus(sourceStatus), .link_timeout_flag(link_timeout_flag));
`default_nettype wire
